// [rtl/dsj_decode.sv]
`timescale 1ns/1ps
`default_nettype none
module dsj_decode
  import dsj_pkg::*;
(
  input wire logic [dsj_pkg::INSN_W-1:0] insn_i,
  output logic is_dec_o,
  output logic is_skip_o,
  output logic is_jump_o,
  output logic dest_reg_o,
  output logic [dsj_pkg::FSEL_W-1:0] fsel_o,
  output logic [dsj_pkg::LIT_W-1:0] lit_o
);
  // ----------------------------------------
  // field extraction
  // ----------------------------------------
  always_comb begin
    is_dec_o = insn_i[INSN_W-1:OPC6_LSB] == OPC_DEC;
    is_skip_o = insn_i[INSN_W-1:OPC6_LSB] == OPC_DECSKIP;
    is_jump_o = insn_i[INSN_W-1:OPC3_LSB] == OPC_JUMP;
    dest_reg_o = insn_i[DEST_BIT];
    fsel_o = insn_i[FSEL_W-1:0];
    lit_o = insn_i[LIT_W-1:0];
  end
endmodule // dsj_decode
`default_nettype wire

// [rtl/dsj_exec.sv]
// Operation
// - pattern 0000 11df ffff: decrement register f, d=0 writes accumulator
// - d=1 writes register f; zero flag updated; one word, one cycle
// - pattern 0010 11df ffff: decrement, route by d, no flag change
// - skip variant: zero result flushes fetched word, two cycles total
// - pattern 101k kkkk kkkk: literal loads counter bits 8..0
// - jump fills counter bits 10..9 from status bits 6..5
// - jump takes two cycles, flushes next fetch, flags unchanged
`timescale 1ns/1ps
`default_nettype none
module dsj_exec
  import dsj_pkg::*;
(
  input wire logic clk_i,
  input wire logic rstn_i,
  input wire logic ce_i,
  input wire logic insn_valid_i,
  input wire logic [dsj_pkg::INSN_W-1:0] insn_i,
  input wire logic [dsj_pkg::DATA_W-1:0] reg_rdata_i,
  input wire logic [dsj_pkg::DATA_W-1:0] status_i,
  output logic [dsj_pkg::FSEL_W-1:0] reg_raddr_o,
  output dsj_pkg::dsj_wr_s wr_o,
  output dsj_pkg::dsj_zf_s zf_o,
  output dsj_pkg::dsj_pc_s pc_o,
  output logic flush_o,
  output logic busy_o
);
  import dsj_pkg::*;

  logic is_dec;
  logic is_skip;
  logic is_jump;
  logic dest_reg;
  logic [FSEL_W-1:0] fsel;
  logic [LIT_W-1:0] lit;

  dsj_decode u_dec (
    .insn_i(insn_i),
    .is_dec_o(is_dec),
    .is_skip_o(is_skip),
    .is_jump_o(is_jump),
    .dest_reg_o(dest_reg),
    .fsel_o(fsel),
    .lit_o(lit)
  );

  // ----------------------------------------
  // next state
  // ----------------------------------------
  dsj_op_e op_reg, op_next;
  dsj_wr_s wr_reg, wr_next;
  dsj_zf_s zf_reg, zf_next;
  dsj_pc_s pc_reg, pc_next;
  logic flush_reg, flush_next;
  logic busy_reg, busy_next;
  logic [FSEL_W-1:0] raddr_reg, raddr_next;
  logic [DATA_W-1:0] result;
  logic active;
  logic in_flush;

  // ----------------------------------------
  // op state summary
  // ----------------------------------------
  always_comb begin
    unique case (op_reg)
      DSJ_OP_NONE: in_flush = 1'b0;
      DSJ_OP_WRITE: in_flush = 1'b0;
      DSJ_OP_FLUSH: in_flush = 1'b1;
    endcase
  end

  always_comb begin
    result = reg_rdata_i - 8'h01;
    active = insn_valid_i && !busy_reg;
    op_next = DSJ_OP_NONE;
    wr_next = '0;
    zf_next = '0;
    pc_next = '0;
    flush_next = 1'b0;
    busy_next = 1'b0;
    raddr_next = fsel;
    if (active && (is_dec || is_skip)) begin
      op_next = DSJ_OP_WRITE;
      wr_next.addr = fsel;
      wr_next.data = result;
      wr_next.wr_acc = !dest_reg;
      wr_next.wr_reg = dest_reg;
      if (is_dec) begin
        zf_next.upd = 1'b1;
        zf_next.val = result == 8'h00;
      end
      if (is_skip && result == 8'h00) begin
        op_next = DSJ_OP_FLUSH;
        flush_next = 1'b1;
        busy_next = 1'b1;
      end
    end else if (active && is_jump) begin
      op_next = DSJ_OP_FLUSH;
      pc_next.load = 1'b1;
      pc_next.target = {status_i[PAGE_LSB+1:PAGE_LSB], lit};
      flush_next = 1'b1;
      busy_next = 1'b1;
    end
  end

  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      op_reg <= DSJ_OP_NONE;
      wr_reg <= '0;
      zf_reg <= '0;
      pc_reg <= '0;
      flush_reg <= 1'b0;
      busy_reg <= 1'b0;
      raddr_reg <= '0;
    end else if (ce_i) begin
      op_reg <= op_next;
      wr_reg <= wr_next;
      zf_reg <= zf_next;
      pc_reg <= pc_next;
      flush_reg <= flush_next;
      busy_reg <= busy_next;
      raddr_reg <= raddr_next;
    end
  end

  // ----------------------------------------
  // outputs
  // ----------------------------------------
  assign reg_raddr_o = raddr_reg;
  assign wr_o = wr_reg;
  assign zf_o = zf_reg;
  assign pc_o = pc_reg;
  assign flush_o = flush_reg;
  assign busy_o = busy_reg;

  // ----------------------------------------
  // checks
  // ----------------------------------------
  chk_dec_acc_dest: assert property (@(posedge clk_i) disable iff (!rstn_i)
    ce_i && insn_valid_i && !busy_reg && is_dec && !dest_reg
    |=> wr_o.wr_acc && !wr_o.wr_reg && wr_o.data == $past(reg_rdata_i) - 8'h01)
    else $error("decrement to accumulator wrong");
  chk_dec_reg_dest: assert property (@(posedge clk_i) disable iff (!rstn_i)
    ce_i && insn_valid_i && !busy_reg && is_dec && dest_reg
    |=> wr_o.wr_reg && wr_o.addr == $past(fsel) && !busy_o)
    else $error("decrement to register wrong");
  chk_skip_noflag: assert property (@(posedge clk_i) disable iff (!rstn_i)
    ce_i && insn_valid_i && !busy_reg && is_skip |=> !zf_o.upd)
    else $error("skip variant touched zero flag");
  chk_skip_flush: assert property (@(posedge clk_i) disable iff (!rstn_i)
    ce_i && insn_valid_i && !busy_reg && is_skip
    |=> flush_o == (wr_o.data == 8'h00) && busy_o == flush_o)
    else $error("skip flush mismatch");
  chk_jump_low: assert property (@(posedge clk_i) disable iff (!rstn_i)
    ce_i && insn_valid_i && !busy_reg && is_jump
    |=> pc_o.load && pc_o.target[LIT_W-1:0] == $past(lit))
    else $error("jump literal wrong");
  chk_jump_page: assert property (@(posedge clk_i) disable iff (!rstn_i)
    ce_i && insn_valid_i && !busy_reg && is_jump
    |=> pc_o.target[PC_W-1:LIT_W] == $past(status_i[PAGE_LSB+1:PAGE_LSB]))
    else $error("jump page wrong");
  chk_jump_twocyc: assert property (@(posedge clk_i) disable iff (!rstn_i)
    ce_i && insn_valid_i && !busy_reg && is_jump
    |=> flush_o && busy_o && !zf_o.upd && !wr_o.wr_acc && !wr_o.wr_reg)
    else $error("jump not two cycles");
  chk_zero_value: assert property (@(posedge clk_i) disable iff (!rstn_i)
    zf_o.upd |-> zf_o.val == (wr_o.data == 8'h00) && (wr_o.wr_acc || wr_o.wr_reg))
    else $error("zero flag value wrong");
  chk_dec_zero_set: assert property (@(posedge clk_i) disable iff (!rstn_i)
    ce_i && insn_valid_i && !busy_reg && is_dec && reg_rdata_i == 8'h01
    |=> zf_o.upd && zf_o.val)
    else $error("zero flag not set on zero result");
  chk_skip_route: assert property (@(posedge clk_i) disable iff (!rstn_i)
    ce_i && insn_valid_i && !busy_reg && is_skip
    |=> wr_o.wr_reg == $past(dest_reg) && wr_o.wr_acc == !$past(dest_reg) && wr_o.addr == $past(fsel))
    else $error("skip variant routed wrong");
  chk_skip_nonzero: assert property (@(posedge clk_i) disable iff (!rstn_i)
    ce_i && insn_valid_i && !busy_reg && is_skip && reg_rdata_i != 8'h01
    |=> !flush_o && !busy_o && (wr_o.wr_acc || wr_o.wr_reg))
    else $error("skip flushed on nonzero result");
  chk_write_onehot: assert property (@(posedge clk_i) disable iff (!rstn_i)
    !(wr_o.wr_acc && wr_o.wr_reg))
    else $error("both destinations written");

  // ----------------------------------------
  // checks: refusal, freeze, state
  // ----------------------------------------
  chk_op_busy: assert property (@(posedge clk_i) disable iff (!rstn_i)
    in_flush == busy_reg)
    else $error("op state and busy disagree");
  chk_busy_refuse: assert property (@(posedge clk_i) disable iff (!rstn_i)
    ce_i && busy_o |=> !wr_o.wr_acc && !wr_o.wr_reg && !pc_o.load && !zf_o.upd)
    else $error("flushed slot produced output");
  chk_flush_single: assert property (@(posedge clk_i) disable iff (!rstn_i)
    ce_i && flush_o |=> !flush_o && !busy_o)
    else $error("flush lasted too long");
  chk_other_quiet: assert property (@(posedge clk_i) disable iff (!rstn_i)
    ce_i && insn_valid_i && !busy_reg && !is_dec && !is_skip && !is_jump
    |=> !wr_o.wr_acc && !wr_o.wr_reg && !zf_o.upd && !pc_o.load && !flush_o)
    else $error("undecoded word produced output");
  chk_freeze_hold: assert property (@(posedge clk_i) disable iff (!rstn_i)
    !ce_i |=> $stable(wr_o) && $stable(zf_o) && $stable(pc_o) && $stable(busy_o))
    else $error("state moved while disabled");
  chk_raddr_copy: assert property (@(posedge clk_i) disable iff (!rstn_i)
    ce_i |=> reg_raddr_o == $past(fsel))
    else $error("read address copy wrong");
endmodule // dsj_exec
`default_nettype wire

// [rtl/dsj_pkg.sv]
package dsj_pkg;
  // ----------------------------------------
  // widths
  // ----------------------------------------
  localparam int INSN_W = 12;
  localparam int DATA_W = 8;
  localparam int FSEL_W = 5;
  localparam int LIT_W = 9;
  localparam int PC_W = 11;
  // ----------------------------------------
  // encodings and field positions
  // ----------------------------------------
  localparam logic [5:0] OPC_DEC = 6'h03;
  localparam logic [5:0] OPC_DECSKIP = 6'h0B;
  localparam logic [2:0] OPC_JUMP = 3'h5;
  localparam int OPC6_LSB = 6;
  localparam int OPC3_LSB = 9;
  localparam int DEST_BIT = 5;
  localparam int PAGE_LSB = 5;
  localparam logic [7:0] STATUS_RST = 8'h00;
  localparam logic [11:0] INSN_RST = 12'h000;

  typedef enum logic [2:0] {
    DSJ_OP_NONE = 3'b001,
    DSJ_OP_WRITE = 3'b010,
    DSJ_OP_FLUSH = 3'b100
  } dsj_op_e;

  typedef struct packed {
    logic wr_acc;
    logic wr_reg;
    logic [FSEL_W-1:0] addr;
    logic [DATA_W-1:0] data;
  } dsj_wr_s;

  typedef struct packed {
    logic load;
    logic [PC_W-1:0] target;
  } dsj_pc_s;

  typedef struct packed {
    logic upd;
    logic val;
  } dsj_zf_s;
endpackage

// [tb/decrement_skip_jump_exec_tb.sv]
`timescale 1ns/1ps
`default_nettype none
module decrement_skip_jump_exec_tb;
  import dsj_pkg::*;
  logic clk_i = 1'b0;
  logic rstn_i = 1'b0;
  logic ce_i = 1'b1;
  logic ce_d = 1'b1;
  logic insn_valid_i = 1'b0;
  logic [INSN_W-1:0] insn_i = INSN_RST;
  logic [DATA_W-1:0] reg_rdata_i = 8'h00;
  logic [DATA_W-1:0] status_i = STATUS_RST;
  dsj_wr_s wr_o;
  dsj_zf_s zf_o;
  dsj_pc_s pc_o;
  logic flush_o;
  logic busy_o;
  logic [FSEL_W-1:0] reg_raddr_o;
  logic [FSEL_W-1:0] raddr_exp = '0;
  logic [30:0] exp_q[$];
  logic [30:0] msk_q[$];
  int err_total = 0;
  int n_checks = 0;
  dsj_exec dut_u (.clk_i(clk_i), .rstn_i(rstn_i), .ce_i(ce_i), .insn_valid_i(insn_valid_i),
    .insn_i(insn_i), .reg_rdata_i(reg_rdata_i), .status_i(status_i), .reg_raddr_o(reg_raddr_o),
    .wr_o(wr_o), .zf_o(zf_o), .pc_o(pc_o), .flush_o(flush_o), .busy_o(busy_o));
  initial begin
    forever #2.5 clk_i = ~clk_i;
  end
  always @(posedge clk_i) ce_d <= ce_i;
  always @(posedge clk_i) if (ce_i) raddr_exp <= insn_i[FSEL_W-1:0];
  always @(negedge clk_i) if (rstn_i) cmp_out(31'(reg_raddr_o), 31'(raddr_exp), 31'h1F);
  task automatic summarize();
    if (err_total == 0 && n_checks > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  task automatic cmp_out(input logic [30:0] got, input logic [30:0] e, input logic [30:0] m);
    n_checks++;
    if ((got & m) !== (e & m)) begin
      err_total++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, e);
    end
  endtask
  // one note per pulse, oldest first
  always @(negedge clk_i) begin
    if (rstn_i && ce_d === 1'b1
        && (|{wr_o.wr_acc, wr_o.wr_reg, zf_o.upd, pc_o.load, flush_o}) === 1'b1) begin
      if (exp_q.size() == 0) cmp_out({wr_o, zf_o, pc_o, flush_o, busy_o}, '0, '1);
      else cmp_out({wr_o, zf_o, pc_o, flush_o, busy_o}, exp_q.pop_front(), msk_q.pop_front());
    end
  end
  task automatic issue(input logic [11:0] w, input logic [7:0] rd, input logic [7:0] st);
    logic [7:0] res;
    logic [30:0] e;
    logic [30:0] m;
    res = rd - 8'h01;
    e = '0;
    m = 31'h6000A003;
    if (w[11:6] == OPC_DEC || w[11:6] == OPC_DECSKIP) begin
      e[30:16] = {~w[5], w[5], w[4:0], res};
      m[28:16] = '1;
      if (w[11:6] == OPC_DEC) e[15:14] = {1'b1, res == 8'h00};
      if (w[11:6] == OPC_DEC) m[14] = 1'b1;
      else e[1:0] = {2{res == 8'h00}};
    end else if (w[11:9] == OPC_JUMP) begin
      e[13:0] = {1'b1, st[6:5], w[8:0], 2'b11};
      m[12:2] = '1;
    end
    @(posedge clk_i);
    insn_i <= w;
    reg_rdata_i <= rd;
    status_i <= st;
    insn_valid_i <= 1'b1;
    if (|{e[30:29], e[15], e[13], e[1]}) begin
      exp_q.push_back(e);
      msk_q.push_back(m);
    end
    if (e[1]) begin
      @(posedge clk_i);
      insn_i <= {OPC_DEC, 6'($urandom)};
    end
  endtask
  initial begin
    logic [31:0] k;
    logic [7:0] rd;
    void'($urandom(32'hca54f399));
    repeat (20) @(posedge clk_i);
    rstn_i <= 1'b1;
    for (int i = 0; i < 80; i++) begin
      k = $urandom;
      rd = (i % 3 == 0) ? 8'h01 : (i % 3 == 1) ? 8'h00 : 8'(k >> 12);
      case (i % 4)
        0: issue({OPC_DEC, k[5:0]}, rd, 8'(k >> 22));
        1: issue({OPC_DECSKIP, k[5:0]}, rd, 8'(k >> 22));
        2: issue({OPC_JUMP, k[8:0]}, rd, 8'(k >> 22));
        default: issue({6'h0A, k[5:0]}, rd, 8'(k >> 22));
      endcase
      if (k[20]) begin
        @(posedge clk_i);
        insn_valid_i <= 1'b0;
        ce_i <= k[21];
        @(posedge clk_i);
        ce_i <= 1'b1;
      end
    end
    @(posedge clk_i);
    insn_valid_i <= 1'b0;
    for (int j = 0; j < 10 && exp_q.size() != 0; j++) @(posedge clk_i);
    if (exp_q.size() != 0) begin
      err_total++;
      $display("ERROR t=%0t got=%h exp=%h", $time, 0, exp_q.size());
    end
    summarize();
  end
endmodule // decrement_skip_jump_exec_tb
`default_nettype wire
